//--- rtl/bdc_params.svh
// Constants of the decade counter: widths, counts and reset values
`ifndef BDC_PARAMS_SVH
`define BDC_PARAMS_SVH

`define BDC_COUNT_W      4
`define BDC_COUNT_ZERO   4'h0
`define BDC_COUNT_ONE    4'h1
`define BDC_COUNT_LAST   4'h9
`define BDC_LOAD_IDLE    1'b1
`define BDC_ENABLE_IDLE  1'b0
`define BDC_CARRY_RESET  1'b0
`define BDC_REL_RESET    2'h0

`endif

//--- rtl/bdc_pkg.sv
// Types of the decade counter
`include "bdc_params.svh"

package bdc_pkg;

  typedef logic [`BDC_COUNT_W-1:0] bdc_count_t;

  typedef enum logic [1:0] {
    BDC_MODE_HOLD,
    BDC_MODE_LOAD,
    BDC_MODE_COUNT
  } bdc_mode_t;

endpackage

//--- rtl/bdc_decade_counter.sv
// Presettable synchronous decade counter with clear, load, two enables and carry out
`timescale 1ns/1ps
`default_nettype none
`include "bdc_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - All four count bits change only on the rising clock edge or on a low clear or reset, all at the same instant.
// - The count outputs change together on one edge, never as a ripple, so no glitches appear.
// - A low load input copies the preset data into the count two edges after the edge that samples it, whatever the enables.
// - A low clear input forces the count to zero at once, without a clock edge and whatever the other inputs.
// - The count advances two edges after load high and both count enables high are sampled, and holds when either enable was low.
// - The carry output is registered: high while the count is nine and the trickle enable, sampled two edges before, was high.
// - While counting the value steps through zero to nine and wraps from nine to zero.
// - Changes on the enables or load alter nothing until a rising clock edge samples them.
module bdc_decade_counter (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Control pins
  input  wire logic              async_clear_n,
  input  wire logic              load_n,
  input  wire logic              parallel_count_enable,
  input  wire logic              trickle_count_enable,
  // Preset data
  input  wire bdc_pkg::bdc_count_t preset_data,
  // Count and carry
  output var  bdc_pkg::bdc_count_t count_out,
  output var  logic              ripple_carry_out
);

  import bdc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Clear: asserts at once, releases through two flops

  logic                   arst_n;
  logic [1:0]             rel_q;
  logic [1:0]             rel_d;

  assign arst_n = rst_n & async_clear_n;

  always_comb begin
    rel_d = {rel_q[0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rel_q <= `BDC_REL_RESET;
    end else begin
      rel_q <= rel_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Load pin synchroniser, idles high

  logic                   load_meta_q;
  logic                   load_meta_d;
  logic                   load_sync_q;
  logic                   load_sync_d;

  always_comb begin
    load_meta_d = load_n;
    load_sync_d = load_meta_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_meta_q <= `BDC_LOAD_IDLE;
      load_sync_q <= `BDC_LOAD_IDLE;
    end else begin
      load_meta_q <= load_meta_d;
      load_sync_q <= load_sync_d;
    end
  end

  logic                   load_s_n;
  assign load_s_n = load_sync_q;

  //////////////////////////////////////////////////////////////////////////////
  // Parallel enable synchroniser

  logic                   enp_meta_q;
  logic                   enp_meta_d;
  logic                   enp_sync_q;
  logic                   enp_sync_d;

  always_comb begin
    enp_meta_d = parallel_count_enable;
    enp_sync_d = enp_meta_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enp_meta_q <= `BDC_ENABLE_IDLE;
      enp_sync_q <= `BDC_ENABLE_IDLE;
    end else begin
      enp_meta_q <= enp_meta_d;
      enp_sync_q <= enp_sync_d;
    end
  end

  logic                   enp_s;
  assign enp_s = enp_sync_q;

  //////////////////////////////////////////////////////////////////////////////
  // Trickle enable synchroniser

  logic                   ent_meta_q;
  logic                   ent_meta_d;
  logic                   ent_sync_q;
  logic                   ent_sync_d;

  always_comb begin
    ent_meta_d = trickle_count_enable;
    ent_sync_d = ent_meta_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ent_meta_q <= `BDC_ENABLE_IDLE;
      ent_sync_q <= `BDC_ENABLE_IDLE;
    end else begin
      ent_meta_q <= ent_meta_d;
      ent_sync_q <= ent_sync_d;
    end
  end

  logic                   ent_s;
  assign ent_s = ent_sync_q;

  //////////////////////////////////////////////////////////////////////////////
  // Preset data synchroniser

  bdc_count_t             data_meta_q;
  bdc_count_t             data_meta_d;
  bdc_count_t             data_sync_q;
  bdc_count_t             data_sync_d;

  always_comb begin
    data_meta_d = preset_data;
    data_sync_d = data_meta_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_meta_q <= `BDC_COUNT_ZERO;
      data_sync_q <= `BDC_COUNT_ZERO;
    end else begin
      data_meta_q <= data_meta_d;
      data_sync_q <= data_sync_d;
    end
  end

  bdc_count_t             data_s;
  assign data_s = data_sync_q;

  //////////////////////////////////////////////////////////////////////////////
  // Mode selection, sampled only at the clock edge

  bdc_mode_t              mode;

  always_comb begin
    if (!load_s_n) begin
      mode = BDC_MODE_LOAD;
    end else if (enp_s && ent_s) begin
      mode = BDC_MODE_COUNT;
    end else begin
      mode = BDC_MODE_HOLD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Count register and carry

  bdc_count_t             count_q;
  bdc_count_t             count_d;
  logic                   carry_q;
  logic                   carry_d;

  always_comb begin
    count_d = count_q;
    unique case (mode)
      BDC_MODE_LOAD: begin
        count_d = data_s;
      end
      BDC_MODE_COUNT: begin
        if (count_q == `BDC_COUNT_LAST) begin
          count_d = `BDC_COUNT_ZERO;
        end else begin
          count_d = count_q + `BDC_COUNT_ONE;
        end
      end
      BDC_MODE_HOLD: begin
        count_d = count_q;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rel_q[1]) begin
    if (!rel_q[1]) begin
      count_q <= `BDC_COUNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Carry flop: follows the next count and the trickle enable

  always_comb begin
    carry_d = ent_s && (count_d == `BDC_COUNT_LAST);
  end

  always_ff @(posedge ref_clk or negedge rel_q[1]) begin
    if (!rel_q[1]) begin
      carry_q <= `BDC_CARRY_RESET;
    end else begin
      carry_q <= carry_d;
    end
  end

  assign count_out        = count_q;
  assign ripple_carry_out = carry_q;

endmodule

`default_nettype wire

//--- bench/bdc_chk.sv
// Checker of the decade counter
`timescale 1ns/1ps
`default_nettype none
module bdc_chk (
  input wire logic ref_clk, rst_n, async_clear_n, load_n, parallel_count_enable, trickle_count_enable,
  input wire logic ripple_carry_out,
  input wire bdc_pkg::bdc_count_t preset_data, count_out
);
  import bdc_pkg::*;
  logic [3:0] ok_q;
  logic [6:0] a_q, b_q, p_q;
  wire [3:0] c = count_out;
  wire go = ok_q[3];
  wire inc = go && p_q[6:4] == 3'h7;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge ref_clk or negedge rst_n or negedge async_clear_n)
    if (!rst_n || !async_clear_n) ok_q <= 4'h0;
    else ok_q <= {ok_q[2:0], 1'h1};
  always_ff @(posedge ref_clk)
    {a_q, b_q, p_q} <= {load_n, parallel_count_enable, trickle_count_enable, preset_data, a_q, b_q};
  chk_clr_zero: assert property (!async_clear_n |-> !c && !ripple_carry_out) else $error("clear");
  chk_ld_copy: assert property (go && !p_q[6] |-> c == p_q[3:0]) else $error("load");
  chk_cnt_step: assert property (inc && $past(c) < 4'h9 |-> c == $past(c) + 4'h1) else $error("step");
  chk_nine_wrap: assert property (inc && $past(c) == 4'h9 |-> !c) else $error("wrap");
  chk_hold_idle: assert property (go && p_q[6] && !inc |-> $stable(c)) else $error("hold");
  chk_carry_nine: assert property (go |-> ripple_carry_out == (c == 4'h9 && p_q[4])) else $error("carry");
  chk_cnt_range: assert property (c <= 4'h9) else $error("range");
  chk_rel_zero: assert property ($rose(async_clear_n) |-> !c) else $error("release");
  cover property (go && !p_q[6]);
  cover property (ripple_carry_out);
  cover property (!async_clear_n);
endmodule
bind bdc_decade_counter bdc_chk u_chk (.*);
`default_nettype wire

//--- bench/bdc_ctl.sv
// Control logic driving the load, enable and preset data pins of the counter
`timescale 1ns/1ps
`default_nettype none
module bdc_ctl (
  input wire logic ref_clk, quiet,
  output var logic load_n, parallel_count_enable, trickle_count_enable,
  output var bdc_pkg::bdc_count_t preset_data
);
  import bdc_pkg::*;
  integer seed = 32'hf35e, r;
  initial {load_n, parallel_count_enable, trickle_count_enable, preset_data} = 7'h40;
  always @(negedge ref_clk) begin
    r = $random(seed);
    {load_n, parallel_count_enable, trickle_count_enable} <= quiet ? 3'h4 :
      {r[2:0] != 3'h0, r[4:3] != 2'h0, r[6:5] != 2'h0};
    preset_data <= r[11:8] % 4'hA;
  end
endmodule
`default_nettype wire

//--- bench/bdc_decade_counter_test.sv
// Testbench of the decade counter
`timescale 1ns/1ps
`default_nettype none
module bdc_decade_counter_test;
  import bdc_pkg::*;
  logic ref_clk = 1'h0, rst_n = 1'h0, async_clear_n = 1'h1, quiet = 1'h1;
  logic load_n, parallel_count_enable, trickle_count_enable, ripple_carry_out;
  bdc_count_t preset_data, count_out, e;
  logic [6:0] s, t;
  logic [4:0] q[$];
  int n_mismatch = 0, n_checks = 0;
  bdc_decade_counter u_dut (.*);
  bdc_ctl u_ctl (.*);
  task automatic check(input logic [4:0] seen, want);
    n_checks++;
    if (seen !== want) n_mismatch++;
    if (seen !== want) $display("MISMATCH carry_count exp %h seen %h", want, seen);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    {s, t} <= {load_n, parallel_count_enable, trickle_count_enable, preset_data, s};
    if (!rst_n || !async_clear_n) e = 4'h0;
    else if (!t[6]) e = t[3:0];
    else if (t[5] && t[4]) e = e == 4'h9 ? 4'h0 : e + 4'h1;
    if (rst_n) q.push_back({e == 4'h9 && t[4] && async_clear_n, e});
  end
  always @(posedge ref_clk) #2 if (q.size() > 0) check({ripple_carry_out, count_out}, q.pop_front());
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'h1;
    for (int i = 0; i < 3; i++) begin
      repeat (4) @(negedge ref_clk);
      quiet <= 1'h0;
      repeat (600) @(negedge ref_clk);
      quiet <= 1'h1;
      repeat (3) @(negedge ref_clk);
      async_clear_n = 1'h0;
      #1 check({ripple_carry_out, count_out}, 5'h00);
      @(negedge ref_clk) async_clear_n = 1'h1;
      $display("round %0d done", i);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
